// file: hdl/pps_port.sv
// host register set of a multi-mode parallel port
// assumes host strobes come from logic on sys_clk_in; cable pins are asynchronous
`default_nettype none
module pps_port
  import pps_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // configuration
  input wire logic port_enable_in,
  input wire logic [BASE_W-1:0] base_addr_in,
  input wire pps_mode_t mode_in,
  input wire logic timeout_clear_sel_in,
  // host i/o cycle
  input wire logic [ADDR_W-1:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  output logic [7:0] io_rdata_out,
  output logic irq_out,
  // cable data lines
  input wire logic [7:0] port_data_lines_in,
  output logic [7:0] port_data_lines_out,
  output logic port_data_lines_oe_out,
  // cable status inputs
  input wire logic printer_fault_input_in,
  input wire logic printer_online_input_in,
  input wire logic paper_out_input_in,
  input wire logic acknowledge_input_in,
  input wire logic printer_busy_in,
  // cable control outputs
  output logic strobe_pin_out_n_out,
  output logic line_feed_pin_n_out,
  output logic printer_initialise_out,
  output logic select_in_pin_n_out
);
  pps_state_t s_q;
  pps_state_t s_d;
  pps_pins_t pins;
  logic hit;
  logic [2:0] off;
  logic epp_mode;
  logic wr_hit;
  logic rd_start;
  logic rd_end;
  logic tmo_set;
  logic wd_expired;
  logic [7:0] status_byte;

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic port_present(input logic [2:0] o, input logic epp);
    port_present = (o <= OFF_CTRL) || epp;
  endfunction

  assign off = io_addr_in[2:0];
  assign hit = port_enable_in && (io_addr_in[ADDR_W-1:3] == base_addr_in);
  assign epp_mode = (mode_in == PPS_MODE_EPP);
  assign wr_hit = io_wr_in && hit && port_present(off, epp_mode);
  assign rd_start = io_rd_in && !s_q.rd_prev && hit;
  assign rd_end = s_q.rd_prev && !io_rd_in;
  assign tmo_set = wd_expired && epp_mode;

  assign pins.pd = port_data_lines_in;
  assign pins.fault = printer_fault_input_in;
  assign pins.online = printer_online_input_in;
  assign pins.paper = paper_out_input_in;
  assign pins.ack = acknowledge_input_in;
  assign pins.busy = printer_busy_in;

  // status: ready is the complement of busy
  assign status_byte = {!s_q.sync2.busy, s_q.sync2.ack, s_q.sync2.paper,
                        s_q.sync2.online, s_q.sync2.fault,
                        2'b00, s_q.tmo};

  // ************************************************************
  // enhanced-cycle watchdog
  // ************************************************************
  pps_watchdog u_watchdog (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .run_in(s_q.epp_active),
    .expired_out(wd_expired)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    // two flops on every cable level, so status reads lag the pins by two cycles
    s_d.sync1 = pins;
    s_d.sync2 = s_q.sync1;
    s_d.rd_prev = io_rd_in;
    s_d.ack_prev = s_q.sync2.ack;
    // host writes
    if (wr_hit) begin
      case (off)
        OFF_DATA: begin
          s_d.data = io_wdata_in;
        end
        OFF_STATUS: begin
          // only EPP mode gives the status port a write path
          if (epp_mode && !timeout_clear_sel_in && io_wdata_in[0]) begin
            s_d.tmo = 1'b0;
          end
        end
        OFF_CTRL: begin
          s_d.ctrl = io_wdata_in[CTL_W-1:0];
        end
        default: begin
          s_d.epp = io_wdata_in;
          s_d.epp_active = 1'b1;
          s_d.epp_wr = 1'b1;
          s_d.epp_low = 1'b0;
        end
      endcase
    end
    // host reads: the answer is captured at the start and held
    if (rd_start) begin
      s_d.rd_status = (off == OFF_STATUS);
      case (off)
        OFF_DATA: begin
          s_d.rdata = s_q.sync2.pd;
        end
        OFF_STATUS: begin
          s_d.rdata = status_byte;
        end
        OFF_CTRL: begin
          s_d.rdata = {2'b00, s_q.ctrl};
        end
        default: begin
          if (epp_mode) begin
            s_d.rdata = s_q.sync2.pd;
            s_d.epp_active = 1'b1;
            s_d.epp_wr = 1'b0;
            s_d.epp_low = 1'b0;
          end else begin
            s_d.rdata = IDLE_READ;
          end
        end
      endcase
    end
    if (rd_end && s_q.rd_status && timeout_clear_sel_in) begin
      s_d.tmo = 1'b0;
    end
    if (rd_end) begin
      s_d.rd_status = 1'b0;
    end
    // enhanced cycle ends once wait has dropped and risen again
    if (s_q.epp_active && !s_q.sync2.busy) begin
      s_d.epp_low = 1'b1;
    end
    if (s_q.epp_active && s_q.epp_low && s_q.sync2.busy) begin
      s_d.epp_active = 1'b0;
      s_d.epp_wr = 1'b0;
    end
    // set beats any clear in the same cycle
    if (tmo_set) begin
      s_d.tmo = 1'b1;
      s_d.epp_active = 1'b0;
      s_d.epp_wr = 1'b0;
    end
    // acknowledge edge interrupt, a one-cycle pulse
    s_d.irq = s_q.ctrl[CTL_IRQ_EN] && s_q.sync2.ack && !s_q.ack_prev;
    // pins
    s_d.pd_out = s_d.epp_wr ? s_d.epp : s_d.data;
    if (mode_in == PPS_MODE_PRINTER || s_d.epp_wr) begin
      s_d.pd_oe = 1'b1;
    end else begin
      s_d.pd_oe = !s_d.ctrl[CTL_DIR];
    end
    s_d.strobe_n = !s_d.ctrl[CTL_STROBE];
    s_d.linefeed_n = !s_d.ctrl[CTL_LINEFEED];
    s_d.init = s_d.ctrl[CTL_INIT];
    s_d.select_n = !s_d.ctrl[CTL_SELECT];
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.data <= DATA_RST;
      s_q.ctrl <= CTRL_RST;
      s_q.epp <= EPP_RST;
      s_q.tmo <= 1'b0;
      s_q.rdata <= IDLE_READ;
      s_q.pd_out <= DATA_RST;
      s_q.pd_oe <= 1'b1;
      s_q.strobe_n <= 1'b1;
      s_q.linefeed_n <= 1'b1;
      s_q.select_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign io_rdata_out = s_q.rdata;
  assign irq_out = s_q.irq;
  assign port_data_lines_out = s_q.pd_out;
  assign port_data_lines_oe_out = s_q.pd_oe;
  assign strobe_pin_out_n_out = s_q.strobe_n;
  assign line_feed_pin_n_out = s_q.linefeed_n;
  assign printer_initialise_out = s_q.init;
  assign select_in_pin_n_out = s_q.select_n;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  decode_miss_a: assert property (
    (io_wr_in && !hit) |=> $stable(s_q.data) && $stable(s_q.ctrl))
    else $error("write outside the window changed a register");
  data_write_a: assert property (
    (wr_hit && off == OFF_DATA) |=> s_q.data == $past(io_wdata_in))
    else $error("data write not captured");
  data_drive_a: assert property (
    (!s_d.epp_wr && !s_q.epp_wr) |=> port_data_lines_out == s_q.data)
    else $error("data lines do not follow the data register");
  // only the start edge loads the answer; later edges of the cycle must leave it
  status_hold_a: assert property (
    (io_rd_in && s_q.rd_prev) |=> $stable(io_rdata_out))
    else $error("read data changed during the read cycle");
  // reset is the antecedent here, so the default disable must not apply
  tmo_reset_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
    reset_in |=> !s_q.tmo)
    else $error("timeout flag survived reset");
  tmo_wclr_a: assert property (
    (wr_hit && off == OFF_STATUS && epp_mode && !timeout_clear_sel_in
     && io_wdata_in[0] && !tmo_set) |=> !s_q.tmo)
    else $error("write of one did not clear the timeout");
  tmo_rclr_a: assert property (
    (rd_end && s_q.rd_status && timeout_clear_sel_in && !tmo_set) |=> !s_q.tmo)
    else $error("read trailing edge did not clear the timeout");
  tmo_set_a: assert property (
    tmo_set |=> s_q.tmo && !s_q.epp_active)
    else $error("timeout not flagged");
  status_zero_a: assert property (
    (rd_start && off == OFF_STATUS) |=> io_rdata_out[2:1] == 2'b00)
    else $error("status bits 1 and 2 not zero");
  status_wlock_a: assert property (
    (wr_hit && off == OFF_STATUS && !epp_mode && !tmo_set) |=> s_q.tmo == $past(s_q.tmo))
    else $error("status written outside the enhanced mode");
  ctrl_high_a: assert property (
    (rd_start && off == OFF_CTRL) |=> io_rdata_out[7:6] == 2'b00)
    else $error("control bits 6 and 7 not zero");
  pin_invert_a: assert property (
    strobe_pin_out_n_out == !s_q.ctrl[CTL_STROBE]
    && printer_initialise_out == s_q.ctrl[CTL_INIT])
    else $error("control pin polarity wrong");
  irq_gate_a: assert property (
    !s_q.ctrl[CTL_IRQ_EN] |=> !irq_out)
    else $error("interrupt raised while disabled");
  dir_printer_a: assert property (
    (mode_in == PPS_MODE_PRINTER) |=> port_data_lines_oe_out)
    else $error("printer mode did not drive the data lines");
  epp_gate_a: assert property (
    (io_wr_in && hit && off > OFF_CTRL && !epp_mode) |=> $stable(s_q.epp))
    else $error("enhanced port written outside the enhanced mode");

  // ************************************************************
  // checks: read answers
  // ************************************************************
  // answers are looked at one cycle after the start edge, the only edge that loads them
  data_read_a: assert property (
    (rd_start && off == OFF_DATA) |=> io_rdata_out == $past(s_q.sync2.pd))
    else $error("data read did not return the line levels");
  status_pins_a: assert property (
    (rd_start && off == OFF_STATUS)
    |=> io_rdata_out[4:3] == {$past(s_q.sync2.online), $past(s_q.sync2.fault)})
    else $error("status pin bits wrong");
  status_tmo_a: assert property (
    (rd_start && off == OFF_STATUS) |=> io_rdata_out[0] == $past(s_q.tmo))
    else $error("status bit 0 does not show the timeout flag");
  ctrl_read_a: assert property (
    (rd_start && off == OFF_CTRL) |=> io_rdata_out == {2'b00, $past(s_q.ctrl)})
    else $error("control read does not match the register");
  enh_read_off_a: assert property (
    (rd_start && off > OFF_CTRL && !epp_mode) |=> io_rdata_out == IDLE_READ)
    else $error("enhanced port read outside the enhanced mode");
  read_miss_a: assert property (
    (io_rd_in && !s_q.rd_prev && !hit) |=> $stable(io_rdata_out))
    else $error("read outside the window changed the answer");

  // ************************************************************
  // checks: registers and pins
  // ************************************************************
  ctrl_write_a: assert property (
    (wr_hit && off == OFF_CTRL) |=> s_q.ctrl == $past(io_wdata_in[CTL_W-1:0]))
    else $error("control write not captured");
  pin_feed_a: assert property (
    line_feed_pin_n_out == !s_q.ctrl[CTL_LINEFEED]
    && select_in_pin_n_out == !s_q.ctrl[CTL_SELECT])
    else $error("feed or select pin polarity wrong");
  irq_edge_a: assert property (
    (s_q.ctrl[CTL_IRQ_EN] && s_q.sync2.ack && !s_q.ack_prev) |=> irq_out)
    else $error("acknowledge edge did not raise the interrupt");
  irq_pulse_a: assert property (
    irq_out |=> !irq_out)
    else $error("interrupt lasted more than one cycle");
  dir_input_a: assert property (
    (mode_in != PPS_MODE_PRINTER && s_d.ctrl[CTL_DIR] && !s_d.epp_wr)
    |=> !port_data_lines_oe_out)
    else $error("direction bit did not release the data lines");
  // a cycle still finishing or timing out may swallow the new write, so skip those
  enh_drive_a: assert property (
    (wr_hit && off > OFF_CTRL && !s_q.epp_active && !tmo_set && !io_rd_in)
    |=> port_data_lines_out == $past(io_wdata_in) && port_data_lines_oe_out)
    else $error("enhanced write did not drive the data lines");
  tmo_mode_a: assert property (
    (!epp_mode && !s_q.tmo) |=> !s_q.tmo)
    else $error("timeout flagged outside the enhanced mode");
  tmo_hold_a: assert property (
    (wr_hit && off == OFF_STATUS && !io_wdata_in[0] && s_q.tmo && !rd_end) |=> s_q.tmo)
    else $error("write of zero cleared the timeout");
endmodule
`default_nettype wire

// file: hdl/pps_watchdog.sv
// enhanced-cycle watchdog: pulses after each fixed time of unbroken run
// assumes run_in comes from logic on the same clock
`default_nettype none
module pps_watchdog
  import pps_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // control
  input wire logic run_in,
  output logic expired_out
);
  pps_wd_t s_q;
  pps_wd_t s_d;

  // ************************************************************
  // counter
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.expired = 1'b0;
    if (!run_in) begin
      s_d.count = '0;
    end else if (s_q.count == WD_W'(TIMEOUT_CYC - 1)) begin
      s_d.expired = 1'b1;
      s_d.count = '0;
    end else begin
      s_d.count = s_q.count + 12'h001;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired_out = s_q.expired;

  // ************************************************************
  // checks
  // ************************************************************
  expire_early_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $rose(run_in) |-> !expired_out [*8])
    else $error("watchdog fired too early");
  expire_run_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    expired_out |-> $past(run_in))
    else $error("watchdog fired without run");
endmodule
`default_nettype wire

// file: inc/pps_pkg.sv
// constants and carrier types for the parallel port register set
// assumes a single 250 MHz clock and a synchronous active-high reset
`default_nettype none
package pps_pkg;
  // ************************************************************
  // port offsets
  // ************************************************************
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_STATUS = 3'h1;
  localparam logic [2:0] OFF_CTRL = 3'h2;
  localparam logic [2:0] OFF_EPP_ADDR = 3'h3;
  localparam int ADDR_W = 16;
  localparam int BASE_W = 13;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTL_STROBE = 0;
  localparam int CTL_LINEFEED = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELECT = 3;
  localparam int CTL_IRQ_EN = 4;
  localparam int CTL_DIR = 5;
  localparam int CTL_W = 6;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [CTL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [7:0] EPP_RST = 8'h00;
  localparam logic [7:0] IDLE_READ = 8'h00;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int TIMEOUT_NS = 10000;
  localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int WD_W = 12;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    PPS_MODE_PRINTER = 2'b00,
    PPS_MODE_BIDIR = 2'b01,
    PPS_MODE_EPP = 2'b10,
    PPS_MODE_ECP = 2'b11
  } pps_mode_t;

  typedef struct packed {
    logic [7:0] pd;
    logic fault;
    logic online;
    logic paper;
    logic ack;
    logic busy;
  } pps_pins_t;

  typedef struct packed {
    pps_pins_t sync1;
    pps_pins_t sync2;
    logic [7:0] data;
    logic [CTL_W-1:0] ctrl;
    logic [7:0] epp;
    logic tmo;
    logic rd_prev;
    logic rd_status;
    logic [7:0] rdata;
    logic ack_prev;
    logic irq;
    logic epp_active;
    logic epp_wr;
    logic epp_low;
    logic [7:0] pd_out;
    logic pd_oe;
    logic strobe_n;
    logic linefeed_n;
    logic init;
    logic select_n;
  } pps_state_t;

  typedef struct packed {
    logic [WD_W-1:0] count;
    logic expired;
  } pps_wd_t;
endpackage
`default_nettype wire

// file: testbench/pps_port_tb.sv
// self-checking bench for the parallel port register set
// assumes host strobes change on the falling clock edge
`default_nettype none
module pps_port_tb
  import pps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // signals
  // ************************************************************
  localparam logic [BASE_W-1:0] BASE = 13'h004f;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic en = 1'b1;
  logic sel = 1'b0;
  pps_mode_t mode = PPS_MODE_PRINTER;
  logic [ADDR_W-1:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, pd_out, v;
  logic oe, irq, stb_n, lf_n, init, sel_n;
  logic fault = 1'b1, online = 1'b1, paper = 1'b0, ack = 1'b0, stall = 1'b1;
  pps_pins_t pins;
  int errors = 0;
  int compares = 0;
  int irq_cnt = 0;
  int n;
  pps_port pps_port_i (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .port_enable_in(en),
    .base_addr_in(BASE), .mode_in(mode), .timeout_clear_sel_in(sel),
    .io_addr_in(addr), .io_wdata_in(wdata), .io_wr_in(wr), .io_rd_in(rd),
    .io_rdata_out(rdata), .irq_out(irq), .port_data_lines_in(pins.pd),
    .port_data_lines_out(pd_out), .port_data_lines_oe_out(oe),
    .printer_fault_input_in(pins.fault), .printer_online_input_in(pins.online),
    .paper_out_input_in(pins.paper), .acknowledge_input_in(pins.ack),
    .printer_busy_in(pins.busy), .strobe_pin_out_n_out(stb_n),
    .line_feed_pin_n_out(lf_n), .printer_initialise_out(init),
    .select_in_pin_n_out(sel_n));
  pps_printer_model pps_printer_model_i (
    .sys_clk_in(sys_clk_in), .dev_data_in(pd_out), .dev_oe_in(oe),
    .periph_data_in(8'h3c), .stall_in(stall), .fault_in(fault), .online_in(online),
    .paper_in(paper), .ack_in(ack), .pins_out(pins));
  initial begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  always @(negedge sys_clk_in) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  // ************************************************************
  // tasks
  // ************************************************************
  function automatic logic [ADDR_W-1:0] at(input logic [2:0] off);
    return {BASE, off};
  endfunction
  task automatic stop_test();
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_a(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge sys_clk_in);
    wr = 1'b0;
  endtask
  // rd held over the start edge and the answer edge
  task automatic rd_a(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    addr = a;
    rd = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    d = rdata;
    rd = 1'b0;
    @(negedge sys_clk_in);
  endtask
  task automatic tmo_chk(input logic exp);
    rd_a(at(3'h1), v);
    chk("timeout flag", {7'h00, exp}, {7'h00, v[0]});
  endtask
  task automatic hang_cycle(input logic [2:0] off);
    stall = 1'b1;
    wr_a(at(off), 8'hc3);
    repeat (TIMEOUT_CYC + 20) @(negedge sys_clk_in);
  endtask
  task automatic irq_try(input logic [7:0] ctl, input int exp);
    ack = 1'b0;
    wr_a(at(3'h2), ctl);
    repeat (6) @(negedge sys_clk_in);
    n = irq_cnt;
    ack = 1'b1;
    repeat (10) @(negedge sys_clk_in);
    chk("irq pulses", exp[7:0], 8'(irq_cnt - n));
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    errors++;
    stop_test();
  end
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (16) @(negedge sys_clk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    rd_a(at(3'h0), v);
    chk("data reset", 8'h00, v);
    rd_a(at(3'h2), v);
    chk("ctrl reset", 8'h00, v);
    chk("pins reset", 8'h0d, {4'h0, stb_n, lf_n, init, sel_n});
    wr_a(at(3'h0), 8'ha5);
    @(negedge sys_clk_in);
    chk("data lines", 8'ha5, pd_out);
    rd_a(at(3'h0), v);
    chk("data read", 8'ha5, v);
    wr_a(at(3'h2), 8'hff);
    rd_a(at(3'h2), v);
    chk("ctrl read", 8'h3f, v);
    chk("pins set", 8'h02, {4'h0, stb_n, lf_n, init, sel_n});
    chk("oe printer", 8'h01, {7'h00, oe});
    mode = PPS_MODE_BIDIR;
    wr_a(at(3'h0), 8'h11);
    repeat (4) @(negedge sys_clk_in);
    chk("oe input", 8'h00, {7'h00, oe});
    rd_a(at(3'h0), v);
    chk("live lines", 8'h3c, v);
    wr_a(at(3'h2), 8'h00);
    mode = PPS_MODE_PRINTER;
    repeat (2) @(negedge sys_clk_in);
    chk("oe output", 8'h01, {7'h00, oe});
    for (int i = 0; i < 4; i++) begin
      fault = i[0];
      online = i[1];
      paper = ~i[0];
      ack = i[0] ^ i[1];
      repeat (4) @(negedge sys_clk_in);
      rd_a(at(3'h1), v);
      chk("status", {1'b0, ack, paper, online, fault, 3'h0}, v);
    end
    // changing a pin mid-read must not reach the answer
    @(negedge sys_clk_in);
    addr = at(3'h1);
    rd = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    v = rdata;
    fault = ~fault;
    repeat (6) @(negedge sys_clk_in);
    chk("frozen status", v, rdata);
    rd = 1'b0;
    irq_try(8'h10, 1);
    irq_try(8'h00, 0);
    wr_a({BASE + 13'h0001, 3'h0}, 8'h77);
    en = 1'b0;
    wr_a(at(3'h0), 8'h77);
    en = 1'b1;
    wr_a(at(3'h4), 8'h66);
    @(negedge sys_clk_in);
    chk("lines kept", 8'h11, pd_out);
    rd_a(at(3'h3), v);
    chk("epp off read", 8'h00, v);
    mode = PPS_MODE_EPP;
    stall = 1'b0;
    wr_a(at(3'h4), 8'h5a);
    @(negedge sys_clk_in);
    chk("epp lines", 8'h5a, pd_out);
    repeat (40) @(negedge sys_clk_in);
    tmo_chk(1'b0);
    stall = 1'b1;
    wr_a(at(3'h7), 8'hc3);
    repeat (TIMEOUT_CYC - 50) @(negedge sys_clk_in);
    tmo_chk(1'b0);
    repeat (100) @(negedge sys_clk_in);
    tmo_chk(1'b1);
    wr_a(at(3'h1), 8'h00);
    tmo_chk(1'b1);
    mode = PPS_MODE_PRINTER;
    wr_a(at(3'h1), 8'h01);
    tmo_chk(1'b1);
    mode = PPS_MODE_EPP;
    wr_a(at(3'h1), 8'h01);
    tmo_chk(1'b0);
    sel = 1'b1;
    hang_cycle(3'h3);
    tmo_chk(1'b1);
    tmo_chk(1'b0);
    hang_cycle(3'h5);
    reset_in = 1'b1;
    repeat (16) @(negedge sys_clk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    tmo_chk(1'b0);
    stop_test();
  end
endmodule
`default_nettype wire

// file: testbench/pps_printer_model.sv
// printer / enhanced peripheral seen from the cable side of the port
// assumes the bench sets the status levels and stall mode
`default_nettype none
module pps_printer_model
  import pps_pkg::*;
(
  // clock
  input wire logic sys_clk_in,
  // device side of the data lines
  input wire logic [7:0] dev_data_in,
  input wire logic dev_oe_in,
  // bench controls
  input wire logic [7:0] periph_data_in,
  input wire logic stall_in,
  input wire logic fault_in,
  input wire logic online_in,
  input wire logic paper_in,
  input wire logic ack_in,
  // cable levels back to the device
  output pps_pins_t pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase_q = 3'h0;
  always @(posedge sys_clk_in) begin
    phase_q <= phase_q + 3'h1;
  end
  // peripheral only drives the lines while the port has let go
  assign pins_out.pd = dev_oe_in ? dev_data_in : periph_data_in;
  assign pins_out.fault = fault_in;
  assign pins_out.online = online_in;
  assign pins_out.paper = paper_in;
  assign pins_out.ack = ack_in;
  // wait low then high every 8 cycles ends a cycle; stalled it never goes low
  assign pins_out.busy = stall_in ? 1'b1 : (phase_q >= 3'h2);
endmodule
`default_nettype wire
